// File: include/stsr_pkg.sv
// Functional notes
// - Ignore all bus activity until SDA falls while SCL is high.
// - Acknowledge only an address equal to the strap address latched at reset.
// - Eighth address bit: one means read, zero means write.
// - Host releases SDA; device pulls SDA low on the ninth clock.
// - A written data byte is acknowledged once stored in its register.
// - Write byte: address+write, command, data, each acknowledged, then stop.
// - Read byte: address+write, command, repeated start, address+read, data.
// - Send byte: address+write and one command, mainly the single conversion.
// - Receive byte returns register chosen by the latest read command.
// - Read codes 00h to 08h select temperatures, status, config, rate, limits.
// - Write codes 09h to 0Eh select config, rate and the four limits.
// - 0Fh starts one conversion; FEh maker ident, FFh revision, read-only.
// - Receive byte right after write byte acknowledges, returns all ones.
// - No bus timeout ever aborts a transfer.
// - Config bit 7 masks the alert output; resets to zero.
// - Config bit 6 requests standby; resets to zero.
// - Config bits 5..0 and rate bits 7..3 read zero, reset zero.
// - Rate bits 2..0 pick 0.0625 to 8 samples/s, doubling; reset 010b.
// - Temperature registers read-only, refreshed alternately after conversions.
// - One count is one degree; all-zero code is zero degrees.
// - Standby stops periodic conversions; only a single conversion updates temperatures; serial port keeps working.
// - Reading status through the read command clears all status flags.
package stsr_pkg;
    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int unsigned     CLK_HZ          = 200_000_000;
    // slowest sample period, code 000b at 0.0625 samples/s
    localparam int unsigned     SLOW_PERIOD_S   = 16;
    localparam longint unsigned SLOW_PERIOD_CYC =
        64'(SLOW_PERIOD_S) * 64'(CLK_HZ);
    localparam logic [1:0]      STRAP_SETTLE    = 2'h2;
    // -------------------------------------------------------------
    // command codes
    // -------------------------------------------------------------
    localparam logic [7:0] CMD_RD_INTERNAL_TEMP  = 8'h00;
    localparam logic [7:0] CMD_RD_EXTERNAL_TEMP  = 8'h01;
    localparam logic [7:0] CMD_RD_STATUS         = 8'h02;
    localparam logic [7:0] CMD_RD_CONFIG         = 8'h03;
    localparam logic [7:0] CMD_RD_RATE           = 8'h04;
    localparam logic [7:0] CMD_RD_INT_HIGH       = 8'h05;
    localparam logic [7:0] CMD_RD_INT_LOW        = 8'h06;
    localparam logic [7:0] CMD_RD_EXT_HIGH       = 8'h07;
    localparam logic [7:0] CMD_RD_EXT_LOW        = 8'h08;
    localparam logic [7:0] CMD_WR_CONFIG         = 8'h09;
    localparam logic [7:0] CMD_WR_RATE           = 8'h0a;
    localparam logic [7:0] CMD_WR_INT_HIGH       = 8'h0b;
    localparam logic [7:0] CMD_WR_INT_LOW        = 8'h0c;
    localparam logic [7:0] CMD_WR_EXT_HIGH       = 8'h0d;
    localparam logic [7:0] CMD_WR_EXT_LOW        = 8'h0e;
    localparam logic [7:0] CMD_SINGLE_CONVERSION = 8'h0f;
    localparam logic [7:0] CMD_RD_MAKER_IDENT    = 8'hfe;
    localparam logic [7:0] CMD_RD_MAKER_REVISION = 8'hff;
    // -------------------------------------------------------------
    // fields and reset values
    // -------------------------------------------------------------
    localparam int         CFG_MASK_BIT   = 7;
    localparam int         CFG_STANDBY_PIN_N_BIT   = 6;
    localparam int         RATE_CODE_W    = 3;
    localparam logic [7:0] CFG_RESET      = 8'h00;
    localparam logic [7:0] RATE_RESET     = 8'h02;
    localparam logic [7:0] TEMP_RESET     = 8'h00;
    localparam logic [7:0] LIMIT_HI_RESET = 8'h7f;
    localparam logic [7:0] LIMIT_LO_RESET = 8'hc9;
    localparam logic [7:0] ERROR_BYTE     = 8'hff;
    localparam logic [3:0] BYTE_BITS      = 4'h8;
    localparam logic [3:0] LAST_BIT       = 4'h7;
    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_AACK, S_RX, S_RACK, S_TX, S_TACK, S_IGN
    } stsr_state_t;
endpackage

// File: verilog/stsr_slave.sv
`timescale 1ns/1ps
module stsr_slave #(
    parameter int unsigned SLOW_CYC   = 32'(stsr_pkg::SLOW_PERIOD_CYC),
    // arbitrary identification values
    parameter logic [7:0]  MAKER_ID   = 8'h5a,
    parameter logic [7:0]  MAKER_REV  = 8'h01
) (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oen_o,
    input  wire logic [6:0] addr_strap_i,
    input  wire logic       standby_pin_n_i,
    input  wire logic [7:0] status_i,
    output logic            status_clear_o,
    output logic            conv_start_o,
    output logic            conv_sel_ext_o,
    output logic            conv_busy_o,
    input  wire logic [7:0] conv_data_i,
    input  wire logic       conv_done_i,
    output logic            alert_mask_bit_o,
    output logic            standby_o,
    output logic [7:0]      internal_high_limit_o,
    output logic [7:0]      internal_low_limit_o,
    output logic [7:0]      external_high_limit_o,
    output logic [7:0]      external_low_limit_o
);
    import stsr_pkg::*;

    // -------------------------------------------------------------
    // pin synchronisers and edge detection
    // -------------------------------------------------------------
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic [1:0] standby_pin_n_sync_r;
    logic [6:0] strap_s1_r;
    logic [6:0] strap_s2_r;
    logic       scl_d_r;
    logic       sda_d_r;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            scl_sync_r  <= 2'h3;
            sda_sync_r  <= 2'h3;
            standby_pin_n_sync_r <= 2'h3;
            scl_d_r     <= 1'b1;
            sda_d_r     <= 1'b1;
        end else begin
            scl_sync_r  <= {scl_sync_r[0], scl_i};
            sda_sync_r  <= {sda_sync_r[0], sda_i};
            standby_pin_n_sync_r <= {standby_pin_n_sync_r[0], standby_pin_n_i};
            scl_d_r     <= scl_sync_r[1];
            sda_d_r     <= sda_sync_r[1];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        strap_s1_r <= addr_strap_i;
        strap_s2_r <= strap_s1_r;
    end

    wire scl_s     = scl_sync_r[1];
    wire sda_s     = sda_sync_r[1];
    wire scl_rise  = scl_s & ~scl_d_r;
    wire scl_fall  = ~scl_s & scl_d_r;
    wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // -------------------------------------------------------------
    // strap address latch after reset release
    // -------------------------------------------------------------
    logic [1:0] settle_r;
    logic [6:0] my_addr_r;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            settle_r  <= 2'h0;
            my_addr_r <= 7'h00;
        end else if (settle_r != STRAP_SETTLE) begin
            settle_r  <= settle_r + 2'h1;
            my_addr_r <= strap_s2_r;
        end
    end

    // -------------------------------------------------------------
    // serial engine
    // -------------------------------------------------------------
    stsr_state_t state_r, state_nxt;
    logic [3:0]  bit_cnt_r, bit_cnt_nxt;
    logic [7:0]  shift_r, shift_nxt;
    logic [1:0]  byte_idx_r, byte_idx_nxt;
    logic        sda_oen_r, sda_oen_nxt;
    logic        rw_r;
    logic [7:0]  ptr_r;
    logic        err_r;
    logic        tx_load;

    wire [7:0] byte_in  = {shift_r[6:0], sda_s};
    wire       got_byte = scl_rise && bit_cnt_r == LAST_BIT;
    wire       addr_hit = shift_r[7:1] == my_addr_r;
    wire       in_write = state_r == S_RX;
    wire       cmd_stb  = got_byte && in_write && byte_idx_r == 2'h0;
    wire       wr_stb   = got_byte && in_write && byte_idx_r == 2'h1;
    wire       is_rd_cmd = byte_in <= CMD_RD_EXT_LOW
                        || byte_in == CMD_RD_MAKER_IDENT
                        || byte_in == CMD_RD_MAKER_REVISION;
    wire       cmd_os   = cmd_stb && byte_in == CMD_SINGLE_CONVERSION;
    logic [7:0] cmd_r;
    logic [7:0] cfg_r;
    logic [7:0] rate_r;
    logic [7:0] int_temp_r;
    logic [7:0] external_temperature_r;
    logic [7:0] lim_ih_r;
    logic [7:0] lim_il_r;
    logic [7:0] lim_eh_r;
    logic [7:0] lim_el_r;

    // read selection, last read command picks the source
    wire [7:0] reg_rd =
        (ptr_r == CMD_RD_INTERNAL_TEMP)  ? int_temp_r :
        (ptr_r == CMD_RD_EXTERNAL_TEMP)  ? external_temperature_r :
        (ptr_r == CMD_RD_STATUS)         ? status_i   :
        (ptr_r == CMD_RD_CONFIG)         ? cfg_r      :
        (ptr_r == CMD_RD_RATE)           ? rate_r     :
        (ptr_r == CMD_RD_INT_HIGH)       ? lim_ih_r   :
        (ptr_r == CMD_RD_INT_LOW)        ? lim_il_r   :
        (ptr_r == CMD_RD_EXT_HIGH)       ? lim_eh_r   :
        (ptr_r == CMD_RD_EXT_LOW)        ? lim_el_r   :
        (ptr_r == CMD_RD_MAKER_IDENT)    ? MAKER_ID   :
        (ptr_r == CMD_RD_MAKER_REVISION) ? MAKER_REV  : 8'h00;
    wire [7:0] tx_byte = err_r ? ERROR_BYTE : reg_rd;

    // no timeout: states wait on bus edges only
    always_comb begin
        state_nxt    = state_r;
        bit_cnt_nxt  = bit_cnt_r;
        shift_nxt    = shift_r;
        byte_idx_nxt = byte_idx_r;
        sda_oen_nxt  = sda_oen_r;
        tx_load      = 1'b0;
        if (start_det) begin
            state_nxt    = S_ADDR;
            bit_cnt_nxt  = 4'h0;
            byte_idx_nxt = 2'h0;
            sda_oen_nxt  = 1'b1;
        end else if (stop_det) begin
            state_nxt   = S_IDLE;
            sda_oen_nxt = 1'b1;
        end else begin
            unique case (state_r)
                S_IDLE, S_IGN: begin
                    sda_oen_nxt = 1'b1;
                end
                S_ADDR, S_RX: begin
                    if (scl_rise && bit_cnt_r < BYTE_BITS) begin
                        shift_nxt   = byte_in;
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end else if (scl_fall && bit_cnt_r == BYTE_BITS) begin
                        if (state_r == S_RX) begin
                            state_nxt   = S_RACK;
                            sda_oen_nxt = 1'b0;
                        end else if (addr_hit) begin
                            state_nxt   = S_AACK;
                            sda_oen_nxt = 1'b0;
                        end else begin
                            state_nxt = S_IGN;
                        end
                    end
                end
                S_AACK: begin
                    if (scl_fall) begin
                        bit_cnt_nxt = 4'h0;
                        if (rw_r) begin
                            state_nxt   = S_TX;
                            tx_load     = 1'b1;
                            shift_nxt   = tx_byte;
                            sda_oen_nxt = tx_byte[7];
                        end else begin
                            state_nxt   = S_RX;
                            sda_oen_nxt = 1'b1;
                        end
                    end
                end
                S_RACK: begin
                    if (scl_fall) begin
                        state_nxt   = S_RX;
                        bit_cnt_nxt = 4'h0;
                        sda_oen_nxt = 1'b1;
                        if (byte_idx_r != 2'h2)
                            byte_idx_nxt = byte_idx_r + 2'h1;
                    end
                end
                S_TX: begin
                    if (scl_fall && bit_cnt_r == LAST_BIT) begin
                        state_nxt   = S_TACK;
                        sda_oen_nxt = 1'b1;
                    end else if (scl_fall) begin
                        shift_nxt   = {shift_r[6:0], 1'b0};
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                        sda_oen_nxt = shift_r[6];
                    end
                end
                S_TACK: begin
                    if (scl_rise && sda_s) begin
                        state_nxt = S_IGN;
                    end else if (scl_fall) begin
                        state_nxt   = S_TX;
                        bit_cnt_nxt = 4'h0;
                        tx_load     = 1'b1;
                        shift_nxt   = tx_byte;
                        sda_oen_nxt = tx_byte[7];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_r    <= S_IDLE;
            bit_cnt_r  <= 4'h0;
            shift_r    <= 8'h00;
            byte_idx_r <= 2'h0;
            sda_oen_r  <= 1'b1;
        end else begin
            state_r    <= state_nxt;
            bit_cnt_r  <= bit_cnt_nxt;
            shift_r    <= shift_nxt;
            byte_idx_r <= byte_idx_nxt;
            sda_oen_r  <= sda_oen_nxt;
        end
    end

    // direction, command pointer and error flag
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rw_r  <= 1'b0;
            cmd_r <= 8'h00;
            ptr_r <= CMD_RD_INTERNAL_TEMP;
            err_r <= 1'b0;
        end else begin
            if (got_byte && state_r == S_ADDR)
                rw_r <= sda_s;
            if (cmd_stb)
                cmd_r <= byte_in;
            if (cmd_stb && is_rd_cmd) begin
                ptr_r <= byte_in;
                err_r <= 1'b0;
            end else if (wr_stb) begin
                err_r <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------
    // register file writes
    // -------------------------------------------------------------
    wire wr_cfg  = wr_stb && cmd_r == CMD_WR_CONFIG;
    wire wr_rate = wr_stb && cmd_r == CMD_WR_RATE;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cfg_r    <= CFG_RESET;
            rate_r   <= RATE_RESET;
            lim_ih_r <= LIMIT_HI_RESET;
            lim_il_r <= LIMIT_LO_RESET;
            lim_eh_r <= LIMIT_HI_RESET;
            lim_el_r <= LIMIT_LO_RESET;
        end else begin
            if (wr_cfg)
                cfg_r <= {byte_in[7:6], 6'h00};
            if (wr_rate)
                rate_r <= {5'h00, byte_in[2:0]};
            if (wr_stb && cmd_r == CMD_WR_INT_HIGH)
                lim_ih_r <= byte_in;
            if (wr_stb && cmd_r == CMD_WR_INT_LOW)
                lim_il_r <= byte_in;
            if (wr_stb && cmd_r == CMD_WR_EXT_HIGH)
                lim_eh_r <= byte_in;
            if (wr_stb && cmd_r == CMD_WR_EXT_LOW)
                lim_el_r <= byte_in;
        end
    end

    // -------------------------------------------------------------
    // conversion sequencer
    // -------------------------------------------------------------
    logic [31:0] rate_cnt_r;
    logic        busy_r;
    logic        sel_ext_r;
    logic        start_r;
    logic        os_pend_r;
    logic        os_run_r;
    logic        stat_clr_r;

    wire        standby_pin_n    = ~standby_pin_n_sync_r[1] | cfg_r[CFG_STANDBY_PIN_N_BIT];
    wire [31:0] period  = SLOW_CYC >> rate_r[RATE_CODE_W-1:0];
    wire        tick    = rate_cnt_r >= period - 32'h1;
    wire        trig    = ~busy_r & ((tick & ~standby_pin_n) | os_pend_r);
    wire        halt    = standby_pin_n & ~os_run_r;
    wire        take    = conv_done_i & busy_r & ~halt;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || standby_pin_n || tick)
            rate_cnt_r <= 32'h0;
        else
            rate_cnt_r <= rate_cnt_r + 32'h1;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            busy_r     <= 1'b0;
            sel_ext_r  <= 1'b0;
            start_r    <= 1'b0;
            os_pend_r  <= 1'b0;
            os_run_r   <= 1'b0;
            int_temp_r <= TEMP_RESET;
            external_temperature_r <= TEMP_RESET;
        end else begin
            start_r   <= trig | (take & ~sel_ext_r);
            os_pend_r <= cmd_os | (os_pend_r & ~trig);
            if (trig) begin
                busy_r    <= 1'b1;
                sel_ext_r <= 1'b0;
                os_run_r  <= os_pend_r;
            end else if (busy_r && halt) begin
                busy_r <= 1'b0;
            end else if (take && !sel_ext_r) begin
                int_temp_r <= conv_data_i;
                sel_ext_r  <= 1'b1;
            end else if (take) begin
                external_temperature_r <= conv_data_i;
                busy_r     <= 1'b0;
                os_run_r   <= 1'b0;
            end
        end
    end

    // status read clears flags
    always_ff @(posedge ref_clk_i) begin
        if (rst_i)
            stat_clr_r <= 1'b0;
        else
            stat_clr_r <= tx_load && !err_r
                       && ptr_r == CMD_RD_STATUS;
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sda_o            <= 1'b0;
            alert_mask_bit_o <= 1'b0;
            standby_o        <= 1'b0;
        end else begin
            sda_o            <= 1'b0;
            alert_mask_bit_o <= cfg_r[CFG_MASK_BIT];
            standby_o        <= halt;
        end
    end

    assign sda_oen_o             = sda_oen_r;
    assign status_clear_o        = stat_clr_r;
    assign conv_start_o          = start_r;
    assign conv_sel_ext_o        = sel_ext_r;
    assign conv_busy_o           = busy_r;
    assign internal_high_limit_o = lim_ih_r;
    assign internal_low_limit_o  = lim_il_r;
    assign external_high_limit_o = lim_eh_r;
    assign external_low_limit_o  = lim_el_r;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_data_end;
        scl_fall && state_r == S_RX && bit_cnt_r == BYTE_BITS;
    endsequence
    sequence s_ack_slot;
        !sda_oen_r && state_r == S_RACK;
    endsequence

    a_idle_until_start: assert property (
        state_r == S_IDLE && !start_det |=> state_r == S_IDLE)
        else $error("left idle without a start");
    a_addr_nomatch: assert property (
        scl_fall && state_r == S_ADDR && bit_cnt_r == BYTE_BITS
        && !addr_hit |=> sda_oen_r && state_r == S_IGN)
        else $error("acknowledged a foreign address");
    a_read_dir: assert property (
        scl_fall && state_r == S_AACK && rw_r && !start_det
        && !stop_det |=> state_r == S_TX)
        else $error("read bit did not turn the bus");
    a_data_ack: assert property (
        s_data_end and !start_det and !stop_det |=> s_ack_slot)
        else $error("no acknowledge after a received byte");
    a_store_first: assert property (
        wr_stb && cmd_r == CMD_WR_INT_HIGH
        |=> lim_ih_r == $past(byte_in) ##[1:400] s_ack_slot)
        else $error("limit not stored before acknowledge");
    a_reserved_zero: assert property (
        cfg_r[5:0] == 6'h00 && rate_r[7:3] == 5'h00)
        else $error("reserved bits set");
    a_error_byte: assert property (
        tx_load && err_r |=> shift_r == ERROR_BYTE)
        else $error("receive after write did not return ones");
    a_status_clear: assert property (
        tx_load && !err_r && ptr_r == CMD_RD_STATUS
        |=> status_clear_o ##1 !status_clear_o)
        else $error("status read did not clear once");
    a_standby_hold: assert property (
        halt && !trig |=> !conv_start_o && $stable(int_temp_r)
        && $stable(external_temperature_r))
        else $error("conversion while in standby");
    a_restart: assert property (
        start_det |=> state_r == S_ADDR && bit_cnt_r == 4'h0)
        else $error("repeated start did not restart address");
    a_ignore_quiet: assert property (
        state_r == S_IGN |-> sda_oen_r)
        else $error("drove the bus while ignoring");
    a_cfg_write: assert property (
        wr_cfg |=> ##1 alert_mask_bit_o == $past(byte_in[CFG_MASK_BIT], 2))
        else $error("mask not taken");
endmodule // stsr_slave

// File: tb/stsr_host.sv
`timescale 1ns/1ps
// --------------------------------
// bus master model, 48 ns bit time
// --------------------------------
module stsr_host (
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    logic ack_ok;
    initial begin
        scl_o  = 1'b1;
        sda_o  = 1'b1;
        ack_ok = 1'b1;
    end
    task automatic start();
        sda_o = 1'b1;
        #24;
        scl_o = 1'b1;
        #24;
        sda_o = 1'b0;
        #24;
        scl_o = 1'b0;
    endtask
    task automatic stop();
        sda_o = 1'b0;
        #24;
        scl_o = 1'b1;
        #24;
        sda_o = 1'b1;
        #24;
    endtask
    // data only changes while clock is low
    task automatic bit_x(input logic b, output logic r);
        sda_o = b;
        #24;
        scl_o = 1'b1;
        #12;
        r = sda_i;
        #12;
        scl_o = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                        output logic ack);
        for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
        bit_x(1'b1, ack);
    endtask
    task automatic wr(input logic [7:0] b);
        logic [7:0] rx;
        logic       ack;
        xfer(b, rx, ack);
        if (ack !== 1'b0) ack_ok = 1'b0;
    endtask
    task automatic rd(output logic [7:0] d);
        logic ack;
        xfer(8'hff, d, ack);
    endtask
    task automatic write_byte(input logic [6:0] a, input logic [7:0] c, d);
        start();
        wr({a, 1'b0});
        wr(c);
        wr(d);
        stop();
    endtask
    task automatic read_byte(input logic [6:0] a, input logic [7:0] c,
                             output logic [7:0] d);
        start();
        wr({a, 1'b0});
        wr(c);
        start();
        wr({a, 1'b1});
        rd(d);
        stop();
    endtask
    task automatic send_byte(input logic [6:0] a, input logic [7:0] c);
        start();
        wr({a, 1'b0});
        wr(c);
        stop();
    endtask
    task automatic recv_byte(input logic [6:0] a, output logic [7:0] d);
        start();
        wr({a, 1'b1});
        rd(d);
        stop();
    endtask
endmodule // stsr_host

// File: tb/test_stsr_slave.sv
`timescale 1ns/1ps
module test_stsr_slave;
    import stsr_pkg::*;
    localparam logic [6:0] ADDR = 7'h4c;
    // arbitrary identification values
    localparam logic [7:0] ID = 8'h3c;
    localparam logic [7:0] REV = 8'h02;
    logic       clk, rst_i, scl, sda_h, sda_w, oen, sdo, stb_n, done, clr;
    logic       cst, sel, busy, amask, standby_pin_n;
    logic [7:0] st, cdat, rd, ihl, ill, ehl, ell;
    logic [2:0] pend;
    int         errors, check_count;
    logic [31:0] rows [7] = '{32'h09ff03c0, 32'h0aff0407, 32'h0b190519,
        32'h0ce706e7, 32'h0d7e077e, 32'h0ec808c8, 32'h0a000400};
    assign sda_w = sda_h & (oen | sdo);
    stsr_host u_host (.sda_i(sda_w), .scl_o(scl), .sda_o(sda_h));
    stsr_slave #(.SLOW_CYC(800), .MAKER_ID(ID), .MAKER_REV(REV)) u_dut (
        .ref_clk_i(clk), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sdo), .sda_oen_o(oen), .addr_strap_i(ADDR),
        .standby_pin_n_i(stb_n), .status_i(st), .status_clear_o(clr),
        .conv_start_o(cst), .conv_sel_ext_o(sel), .conv_busy_o(busy),
        .conv_data_i(cdat), .conv_done_i(done), .alert_mask_bit_o(amask),
        .standby_o(standby_pin_n), .internal_high_limit_o(ihl),
        .internal_low_limit_o(ill), .external_high_limit_o(ehl),
        .external_low_limit_o(ell));
    // --------------------------------
    // converter and status stand-ins
    // --------------------------------
    always @(negedge clk) begin
        pend <= {pend[1:0], cst};
        done <= pend[2];
        cdat <= sel ? 8'he7 : 8'h19;
        if (rst_i) st <= 8'h48;
        else if (clr) st <= 8'h00;
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic do_reset();
        rst_i = 1'b1;
        repeat (6) @(negedge clk);
        rst_i = 1'b0;
        repeat (12) @(negedge clk);
    endtask
    initial begin
        #400000;
        errors++;
        print_verdict();
    end
    initial begin
        {errors, check_count, pend, done, rst_i, stb_n} = '0;
        {st, cdat} = '0;
        do_reset();
        for (int i = 0; i < 7; i++) begin
            u_host.ack_ok = 1'b1;
            u_host.write_byte(ADDR, rows[i][31:24], rows[i][23:16]);
            u_host.read_byte(ADDR, rows[i][15:8], rd);
            check({7'h0, u_host.ack_ok}, 8'h01);
            check(rd, rows[i][7:0]);
        end
        @(negedge clk) stb_n = 1'b1;
        repeat (4) @(negedge clk);
        check({amask, standby_pin_n, 6'h0}, 8'hc0);
        check(ehl ^ ell, 8'h7e ^ 8'hc8);
        u_host.send_byte(ADDR, CMD_SINGLE_CONVERSION);
        u_host.read_byte(ADDR, CMD_RD_INTERNAL_TEMP, rd);
        check(rd, 8'h19);
        u_host.recv_byte(ADDR, rd);
        check(rd, 8'h19);
        u_host.read_byte(ADDR, CMD_RD_EXTERNAL_TEMP, rd);
        check(rd, 8'he7);
        u_host.write_byte(ADDR, CMD_WR_INT_LOW, 8'h01);
        u_host.recv_byte(ADDR, rd);
        check(rd, ERROR_BYTE);
        u_host.read_byte(ADDR, CMD_RD_MAKER_IDENT, rd);
        check(rd, ID);
        u_host.read_byte(ADDR, CMD_RD_MAKER_REVISION, rd);
        check(rd, REV);
        u_host.read_byte(ADDR, CMD_RD_STATUS, rd);
        check(rd, 8'h48);
        u_host.read_byte(ADDR, CMD_RD_STATUS, rd);
        check(rd, 8'h00);
        u_host.ack_ok = 1'b1;
        u_host.write_byte(ADDR ^ 7'h01, CMD_WR_INT_HIGH, 8'h00);
        check({7'h0, u_host.ack_ok}, 8'h00);
        check(ihl, 8'h19);
        @(negedge clk) stb_n = 1'b0;
        do_reset();
        check(ihl ^ ill, LIMIT_HI_RESET ^ LIMIT_LO_RESET);
        u_host.read_byte(ADDR, CMD_RD_CONFIG, rd);
        check(rd, CFG_RESET);
        u_host.read_byte(ADDR, CMD_RD_RATE, rd);
        check(rd, RATE_RESET);
        u_host.read_byte(ADDR, CMD_RD_INTERNAL_TEMP, rd);
        check(rd, TEMP_RESET);
        @(negedge clk) stb_n = 1'b1;
        repeat (180) @(negedge clk);
        check({7'h0, busy}, 8'h00);
        repeat (26) @(negedge clk);
        check({7'h0, busy}, 8'h01);
        u_host.read_byte(ADDR, CMD_RD_EXTERNAL_TEMP, rd);
        check(rd, 8'he7);
        print_verdict();
    end
endmodule // test_stsr_slave
